//--- verilog/snc_host.sv
// Host controller driving a serial NAND flash over single/quad SPI pins.
// Assumes mode-0 device, software on Avalon-MM, clock divider made here.
//
// Contract
// - Status write sends opcode 1F or 01, register address, one data byte.
// - Opcode 06 framed by chip select sets the write enable latch.
// - Write enable latch must be set before load, execute and erase.
// - Opcode 04 framed by chip select clears the write enable latch.
// - Block erase is opcode D8 with 24-bit page address.
// - Chip select rises exactly on a byte boundary after erase address.
// - Load is 02 or 84, 16-bit column with twelve live bits, data.
// - Chip select stays low for the whole load; overflow bytes dropped.
// - Quad loads 32 and 34 send data on all four lines.
// - Program execute is opcode 10 with 24-bit page address.
// - Pages within a block are programmed in ascending order only; the host checks against the last page programmed only.
// - Data read from one plane is never programmed into another.
// - Page read is opcode 13 with 24-bit page address.
`include "snc_regs.svh"

module snc_host
   import snc_pkg::*;
#(
   parameter int HALF_DIV = 4,
   parameter int BUF_BYTES = 2176,
   parameter int PLANE_BIT = 6
) (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Avalon-MM slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Flash pins
   output logic flash_cs_n,
   output logic flash_sclk,
   output logic [3:0] flash_io_o,
   output logic [3:0] flash_io_oe,
   input wire logic [3:0] flash_io_i
);

   // Sampling needs the synchroniser lag to fit in a half clock
   if (HALF_DIV < 4 || HALF_DIV > 255 || BUF_BYTES < 1 || BUF_BYTES > 4096
       || PLANE_BIT < `SNC_BLK_LSB || PLANE_BIT > 23) begin : g_bad
      $error("snc_host: unsupported parameter values");
   end

   snc_state_e st_q;
   logic [7:0] div_q;
   logic [31:0] sh_q;
   logic [5:0] left_q;
   logic [15:0] total_q;
   logic [12:0] col_q;
   logic quad_q, dlast_q, drop_q;
   snc_op_t op_q;
   logic [7:0] rd_q;
   logic [3:0] s1_q, s2_q, s3_q, in_q;
   logic [23:0] addr_q;
   logic [7:0] wbyte_q;
   logic wlast_q, wpend_q, wp_q, wel_q;
   snc_err_t err_q;
   logic [23:0] last_pg_q;
   logic pg_vld_q, rdpl_q, rdpl_vld_q, cs_prev_q;

   // Input synchroniser: a bit changes once stages two and three agree
   wire [3:0] in_d = (s2_q & ~(s2_q ^ s3_q)) | (in_q & (s2_q ^ s3_q));
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s1_q <= 4'h0;
         s2_q <= 4'h0;
         s3_q <= 4'h0;
         in_q <= 4'h0;
      end else if (ce) begin
         s1_q <= flash_io_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         in_q <= in_d;
      end
   end

   // Bus decode
   wire acc = (avs_read | avs_write) & ~avs_waitrequest;
   wire acc_wr = acc & avs_write;
   wire sel_cmd = avs_address == `SNC_A_CMD;
   wire sel_addr = avs_address == `SNC_A_ADDR;
   wire sel_wdat = avs_address == `SNC_A_WDATA;
   wire sel_stat = avs_address == `SNC_A_STAT;
   wire sel_cfg = avs_address == `SNC_A_CFG;
   wire stall = avs_write & sel_wdat & wpend_q;
   wire wr_d = ~((avs_read | avs_write) & avs_waitrequest & ~stall);

   // Opcode decode of a command write
   wire [7:0] nop = avs_writedata[7:0];
   wire is_wen = nop == `SNC_OP_WEN;
   wire is_wdis = nop == `SNC_OP_WDIS;
   wire is_wsr = nop == `SNC_OP_WSR_A || nop == `SNC_OP_WSR_B;
   wire is_rsr = nop == `SNC_OP_RSR_A || nop == `SNC_OP_RSR_B;
   wire is_erase = nop == `SNC_OP_ERASE;
   wire is_pexec = nop == `SNC_OP_PEXEC;
   wire is_pread = nop == `SNC_OP_PREAD;
   wire is_quad = nop == `SNC_OP_QLOAD || nop == `SNC_OP_QRLOAD;
   wire is_plain = nop == `SNC_OP_LOAD || nop == `SNC_OP_QLOAD;
   wire is_load = is_plain || is_quad || nop == `SNC_OP_RLOAD;
   wire is_page = is_erase | is_pexec | is_pread;
   wire known = is_wen | is_wdis | is_wsr | is_rsr | is_page | is_load;
   wire needs_wel = is_load | is_erase | is_pexec;

   // Ordering guards for program execute
   wire same_blk = addr_q[23:`SNC_BLK_LSB] == last_pg_q[23:`SNC_BLK_LSB];
   wire seq_bad = is_pexec & pg_vld_q & same_blk
                  & (addr_q[`SNC_BLK_LSB-1:0] <= last_pg_q[`SNC_BLK_LSB-1:0]);
   wire plane_bad = is_pexec & rdpl_vld_q & (addr_q[PLANE_BIT] != rdpl_q);

   // Refusal priority: busy first, then opcode, latch, lock, order
   snc_err_t err_w;
   assign err_w = (st_q != S_IDLE) ? `SNC_E_BUSY :
                  !known ? `SNC_E_OPC :
                  (needs_wel & ~wel_q) ? `SNC_E_WEL :
                  (is_quad & wp_q) ? `SNC_E_WP :
                  seq_bad ? `SNC_E_SEQ :
                  plane_bad ? `SNC_E_PLANE : `SNC_E_NONE;
   wire go = acc_wr & sel_cmd & avs_byteenable[0] & (err_w == `SNC_E_NONE);

   // Header built from opcode, address and staged data byte
   wire [31:0] hdr = is_wsr ? {nop, addr_q[7:0], wbyte_q, 8'h00} :
                     is_rsr ? {nop, addr_q[7:0], 16'h0000} :
                     is_page ? {nop, addr_q} :
                     is_load ? {nop, 4'h0, addr_q[11:0], 8'h00} :
                     {nop, 24'h000000};
   wire [5:0] hlen = is_wsr ? `SNC_LEN_SWR :
                     is_rsr ? `SNC_LEN_SREG :
                     is_page ? `SNC_LEN_PAGE :
                     is_load ? `SNC_LEN_LOAD : `SNC_LEN_OP;

   // Status and read data
   wire [31:0] stat = {16'h0000, rd_q, err_q, drop_q, wel_q, wpend_q,
                       st_q == S_WAIT, st_q != S_IDLE};
   wire [31:0] rdmux = sel_cmd ? {24'h000000, op_q} :
                       sel_addr ? {8'h00, addr_q} :
                       sel_wdat ? {23'h000000, wlast_q, wbyte_q} :
                       sel_stat ? stat :
                       sel_cfg ? {31'h00000000, wp_q} : 32'h00000000;
   wire [23:0] be_mask = {{8{avs_byteenable[2]}}, {8{avs_byteenable[1]}},
                          {8{avs_byteenable[0]}}};
   wire take = (st_q == S_WAIT) & wpend_q;

   // Bus handshake: one wait cycle, then answer; a data write waits longer while a byte is pending
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
      end else if (ce) begin
         avs_waitrequest <= wr_d;
         if (!wr_d) avs_readdata <= rdmux;
      end
   end

   // Software registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         addr_q <= `SNC_ADDR_RST;
         wbyte_q <= 8'h00;
         wlast_q <= 1'b0;
         wpend_q <= 1'b0;
         wp_q <= `SNC_CFG_RST;
         err_q <= `SNC_E_NONE;
      end else if (ce) begin
         if (acc_wr & sel_addr)
            addr_q <= (addr_q & ~be_mask) | (avs_writedata[23:0] & be_mask);
         if (acc_wr & sel_cfg & avs_byteenable[0]) wp_q <= avs_writedata[0];
         if (acc_wr & sel_cmd & avs_byteenable[0]) err_q <= err_w;
         // Stall keeps a new byte from landing on an unsent one
         if (acc_wr & sel_wdat & avs_byteenable[0]) begin
            wbyte_q <= avs_writedata[7:0];
            wlast_q <= avs_writedata[8];
            wpend_q <= 1'b1;
         end else if (take | (go & is_wsr)) begin
            wpend_q <= 1'b0;
         end
      end
   end

   // Latch mirror and program ordering history
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wel_q <= 1'b0;
         last_pg_q <= 24'h000000;
         pg_vld_q <= 1'b0;
         rdpl_q <= 1'b0;
         rdpl_vld_q <= 1'b0;
      end else if (ce && go) begin
         if (is_wen) wel_q <= 1'b1;
         else if (is_wdis | is_page) wel_q <= 1'b0;
         if (is_pexec) begin
            last_pg_q <= addr_q;
            pg_vld_q <= 1'b1;
         end else if (is_erase & same_blk) begin
            pg_vld_q <= 1'b0;
         end
         if (is_pread) begin
            rdpl_q <= addr_q[PLANE_BIT];
            rdpl_vld_q <= 1'b1;
         end else if (is_plain) begin
            rdpl_vld_q <= 1'b0;
         end
      end
   end

   // Bit engine helpers
   wire tick = div_q == 8'(HALF_DIV - 1);
   wire [5:0] lanes = (quad_q && st_q == S_DATA) ? 6'h04 : 6'h01;
   wire [31:0] sh_nx = sh_q << lanes;
   wire [3:0] io_nx = (quad_q && st_q == S_DATA) ? sh_nx[31:28]
                      : {3'b000, sh_nx[31]};
   wire last_bit = left_q == lanes;
   wire fall = tick & flash_sclk;
   wire room = col_q < 13'(BUF_BYTES);
   wire [3:0] dat_io = quad_q ? wbyte_q[7:4] : {3'b000, wbyte_q[7]};

   // Frame engine: data changes on the falling edge, device samples rising
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_q <= S_IDLE;
         div_q <= 8'h00;
         sh_q <= 32'h00000000;
         left_q <= 6'h00;
         total_q <= 16'h0000;
         col_q <= 13'h0000;
         quad_q <= 1'b0;
         dlast_q <= 1'b0;
         drop_q <= 1'b0;
         op_q <= 8'h00;
         rd_q <= 8'h00;
         flash_cs_n <= 1'b1;
         flash_sclk <= 1'b0;
         flash_io_o <= 4'h0;
         flash_io_oe <= 4'h0;
      end else if (ce) begin
         div_q <= tick ? 8'h00 : div_q + 8'h01;
         case (st_q)
            S_IDLE: begin
               div_q <= 8'h00;
               if (go) begin
                  st_q <= S_HDR;
                  flash_cs_n <= 1'b0;
                  sh_q <= hdr;
                  left_q <= hlen;
                  total_q <= 16'h0000;
                  col_q <= {1'b0, addr_q[11:0]};
                  quad_q <= is_quad;
                  drop_q <= 1'b0;
                  op_q <= nop;
                  flash_io_o <= {3'b000, hdr[31]};
                  flash_io_oe <= 4'h1;
               end
            end
            S_HDR, S_RD, S_DATA: begin
               if (tick & ~flash_sclk) flash_sclk <= 1'b1;
               if (fall) begin
                  flash_sclk <= 1'b0;
                  sh_q <= sh_nx;
                  left_q <= left_q - lanes;
                  total_q <= total_q + {10'h000, lanes};
                  flash_io_o <= io_nx;
                  if (st_q == S_RD) rd_q <= {rd_q[6:0], in_q[1]};
                  if (last_bit) begin
                     if (st_q == S_HDR && op_q == `SNC_OP_RSR_A
                         || st_q == S_HDR && op_q == `SNC_OP_RSR_B) begin
                        st_q <= S_RD;
                        left_q <= `SNC_LEN_BYTE;
                        flash_io_oe <= 4'h0;
                     end else if (st_q == S_HDR && (op_q == `SNC_OP_LOAD
                                  || op_q == `SNC_OP_RLOAD || quad_q)) begin
                        st_q <= S_WAIT;
                     end else if (st_q == S_DATA && !dlast_q) begin
                        st_q <= S_WAIT;
                     end else begin
                        st_q <= S_TAIL;
                     end
                  end
               end
            end
            S_WAIT: begin
               div_q <= 8'h00;
               if (take) begin
                  dlast_q <= wlast_q;
                  if (room) begin
                     st_q <= S_DATA;
                     col_q <= col_q + 13'h0001;
                     sh_q <= {wbyte_q, 24'h000000};
                     left_q <= `SNC_LEN_BYTE;
                     flash_io_o <= dat_io;
                     flash_io_oe <= quad_q ? 4'hF : 4'h1;
                  end else begin
                     drop_q <= 1'b1;
                     if (wlast_q) st_q <= S_TAIL;
                  end
               end
            end
            S_TAIL: begin
               if (tick) begin
                  if (!flash_cs_n) begin
                     flash_cs_n <= 1'b1;
                     flash_io_oe <= 4'h0;
                  end else begin
                     st_q <= S_IDLE;
                  end
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   // Chip select one cycle back marks frame edges for the checks
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) cs_prev_q <= 1'b1;
      else if (ce) cs_prev_q <= flash_cs_n;
   end
   wire fr_start = cs_prev_q & ~flash_cs_n;
   wire fr_end = ~cs_prev_q & flash_cs_n;
   wire op_stat_wr = op_q == `SNC_OP_WSR_A || op_q == `SNC_OP_WSR_B;
   wire op_wel = op_q == `SNC_OP_WEN || op_q == `SNC_OP_WDIS;
   chk_stat_len: assert property (fr_end && op_stat_wr |-> total_q == 16'h0018)
      else $error("status write frame not 24 bits");
   chk_wel_len: assert property (fr_end && op_wel |-> total_q == 16'h0008)
      else $error("latch command frame not 8 bits");
   chk_wel_gate: assert property (fr_start && (op_q == `SNC_OP_RLOAD
      || op_q == `SNC_OP_ERASE || op_q == `SNC_OP_PEXEC || op_q == `SNC_OP_LOAD
      || quad_q) |-> $past(wel_q))
      else $error("write command sent without latch set");
   chk_erase_len: assert property (fr_end && op_q == `SNC_OP_ERASE
      |-> total_q == 16'h0020)
      else $error("erase frame not 32 bits");
   chk_byte_edge: assert property (fr_end |-> total_q[2:0] == 3'h0
      && !flash_sclk && $past(flash_sclk, 2) == 1'b0)
      else $error("chip select rose off a byte boundary");
   chk_col_mask: assert property (fr_start && st_q == S_HDR && (quad_q
      || op_q == `SNC_OP_LOAD || op_q == `SNC_OP_RLOAD) |-> sh_q[23:20] == 4'h0)
      else $error("column upper bits not zero");
   chk_cs_held: assert property ((st_q == S_WAIT) [*3] |-> !flash_cs_n
      && !flash_sclk && $stable(flash_io_o))
      else $error("load frame released while waiting");
   chk_quad_lock: assert property (fr_start && quad_q |-> !wp_q)
      else $error("quad command while write protect set");
   chk_quad_lanes: assert property (flash_io_oe[3] |-> quad_q
      && !flash_cs_n && (st_q == S_DATA || st_q == S_WAIT || st_q == S_TAIL))
      else $error("quad lanes driven outside quad data");
   chk_exec_len: assert property (fr_end && op_q == `SNC_OP_PEXEC
      |-> total_q == 16'h0020)
      else $error("program execute frame not 32 bits");
   chk_read_len: assert property (fr_end && op_q == `SNC_OP_PREAD
      |-> total_q == 16'h0020)
      else $error("page read frame not 32 bits");
   cov_erase: cover property (fr_end && op_q == `SNC_OP_ERASE);
   cov_quad_load: cover property (fr_end && quad_q && total_q > 16'h0018);
   cov_stat_read: cover property (fr_end && op_q == `SNC_OP_RSR_A);
   cov_refused: cover property (acc_wr && sel_cmd && err_w == `SNC_E_WEL);
endmodule

//--- include/snc_regs.svh
// Offsets, field positions, reset values and frame lengths of the host
// controller. Assumes a byte-addressed Avalon-MM slave port.
`ifndef SNC_REGS_SVH
`define SNC_REGS_SVH
// Register byte offsets
`define SNC_A_CMD 5'h00
`define SNC_A_ADDR 5'h04
`define SNC_A_WDATA 5'h08
`define SNC_A_STAT 5'h0C
`define SNC_A_CFG 5'h10
// Flash opcodes
`define SNC_OP_WEN 8'h06
`define SNC_OP_WDIS 8'h04
`define SNC_OP_WSR_A 8'h1F
`define SNC_OP_WSR_B 8'h01
`define SNC_OP_RSR_A 8'h0F
`define SNC_OP_RSR_B 8'h05
`define SNC_OP_ERASE 8'hD8
`define SNC_OP_PEXEC 8'h10
`define SNC_OP_PREAD 8'h13
`define SNC_OP_LOAD 8'h02
`define SNC_OP_RLOAD 8'h84
`define SNC_OP_QLOAD 8'h32
`define SNC_OP_QRLOAD 8'h34
// Header lengths in bits
`define SNC_LEN_OP 6'h08
`define SNC_LEN_SREG 6'h10
`define SNC_LEN_SWR 6'h18
`define SNC_LEN_PAGE 6'h20
`define SNC_LEN_LOAD 6'h18
`define SNC_LEN_BYTE 6'h08
// Page bits within a block (64 pages)
`define SNC_BLK_LSB 6
// Status field positions
`define SNC_ST_ACTIVE 0
`define SNC_ST_WAIT 1
`define SNC_ST_PEND 2
`define SNC_ST_WEL 3
`define SNC_ST_DROP 4
// Refusal codes
`define SNC_E_NONE 3'h0
`define SNC_E_BUSY 3'h1
`define SNC_E_OPC 3'h2
`define SNC_E_WEL 3'h3
`define SNC_E_WP 3'h4
`define SNC_E_SEQ 3'h5
`define SNC_E_PLANE 3'h6
// Reset values
`define SNC_CFG_RST 1'b0
`define SNC_ADDR_RST 24'h000000
`endif

//--- include/snc_pkg.sv
// Types shared by the serial NAND host controller.
// Assumes snc_regs.svh carries all numeric constants.
package snc_pkg;
   typedef enum {S_IDLE, S_HDR, S_RD, S_WAIT, S_DATA, S_TAIL} snc_state_e;
   typedef logic [7:0] snc_op_t;
   typedef logic [2:0] snc_err_t;
endpackage

//--- tb/snc_flash_model.sv
// Behavioural serial NAND device answering the host controller's pins.
// Assumes mode 0 framing; busy time is a plain delay, not a real figure.
module snc_flash_model #(
   parameter int BUSY_NS = 2000,
   parameter int PAR_FIRST = 2112 // First spare byte taken for parity
) (
   // Pins as seen on the wire
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic [3:0] io_w,
   output logic [3:0] io_d
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [7:0] sr1_q = 8'h3E;
   logic [7:0] sr2_q = 8'h10;
   logic wel_q = 1'b0;
   logic busy_q = 1'b0;
   logic dout = 1'b0;
   logic [7:0] sh = 8'h00;
   logic [7:0] sout;
   logic [7:0] buf_q [2176];
   logic [7:0] mem [bit [35:0]];
   logic [7:0] rx [$];
   int bc = 0;

   // Released lines never hold a stale answer bit
   assign io_d = {~dout, ~dout, dout, ~dout};

   initial begin
      foreach (buf_q[i]) buf_q[i] = 8'hFF;
   end

   function automatic logic [7:0] sreg(input logic [7:0] a);
      case (a[7:4])
         4'hA: return sr1_q;
         4'hB: return sr2_q;
         4'hC: return {6'h00, wel_q, busy_q};
         default: return 8'h00;
      endcase
   endfunction

   // Decode a finished frame; array work lands when busy ends
   task automatic run();
      logic [23:0] pg;
      logic [7:0] op;
      int c;
      op = rx[0];
      pg = rx.size() > 3 ? {rx[1], rx[2], rx[3]} : 24'h0;
      c = rx.size() > 2 ? int'({rx[1][3:0], rx[2]}) : 0;
      case (op)
         8'h06: wel_q = 1'b1;
         8'h04: wel_q = 1'b0;
         8'h1F, 8'h01: begin
            if (rx.size() == 3 && rx[1][7:4] == 4'hA)
               sr1_q = rx[2];
            if (rx.size() == 3 && rx[1][7:4] == 4'hB)
               sr2_q[7:4] = rx[2][7:4];
         end
         8'h02, 8'h84, 8'h32, 8'h34: begin
            if (wel_q && !(op[5] && sr1_q[0])) begin
               if (!op[2])
                  foreach (buf_q[i]) buf_q[i] = 8'hFF;
               for (int i = 3; i < rx.size(); i++)
                  if (c + i - 3 < 2176)
                     buf_q[c + i - 3] = rx[i];
            end
         end
         8'hD8, 8'h10, 8'h13: begin
            // Erase and program skip when unlatched or protected
            if (rx.size() == 4 && bc == 32 && (op == 8'h13 ||
                  (wel_q && sr1_q[5:2] == 4'h0))) begin
               busy_q = 1'b1;
               #(BUSY_NS);
               if (op == 8'hD8)
                  foreach (mem[k])
                     if (k[35:18] == pg[23:6])
                        mem[k] = 8'hFF;
               for (int k = 0; k < 2176; k++)
                  if (op == 8'h10)
                     // Parity stand-in is zero when correction is on
                     mem[{pg, k[11:0]}] = (sr2_q[4] && k >= PAR_FIRST) ?
                        8'h00 : buf_q[k];
                  else if (op == 8'h13)
                     buf_q[k] = mem.exists({pg, k[11:0]}) ?
                        mem[{pg, k[11:0]}] : 8'hFF;
               wel_q = 1'b0;
               busy_q = 1'b0;
            end
         end
         default: ;
      endcase
   endtask

   // Shift in on rising clock; quad data takes four lines at once
   always @(posedge sclk) begin
      if (!cs_n) begin
         if (rx.size() >= 3 && (rx[0] inside {8'h32, 8'h34})) begin
            sh = {sh[3:0], io_w};
            bc += 4;
         end else begin
            sh = {sh[6:0], io_w[0]};
            bc += 1;
         end
         if (bc % 8 == 0)
            rx.push_back(sh);
      end
   end

   // Answer bits leave on falling clock, MSB first
   always @(negedge sclk) begin
      if (!cs_n && bc >= 16 && bc < 24 && (rx[0] inside {8'h0F, 8'h05})) begin
         sout = sreg(rx[1]);
         dout = sout[23 - bc];
      end else begin
         dout = ~dout;
      end
   end

   always @(negedge cs_n) begin
      bc = 0;
      rx.delete();
   end

   // Status reads are the only thing served while busy
   always @(posedge cs_n) begin
      if (rx.size() > 0 && !(busy_q && !(rx[0] inside {8'h0F, 8'h05})))
         run();
   end
endmodule

//--- tb/tb_snc_host.sv
// Self-checking bench for the serial NAND host controller.
// Assumes the behavioural device model sits on the flash pins.
`include "snc_regs.svh"

module tb_snc_host
   import snc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct {
      snc_op_t op;
      logic [23:0] addr;
      snc_err_t code;
      logic write_enable_latch;
   } snc_row_s;

   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic [3:0] avs_byteenable = 4'hF;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic [31:0] rd;
   logic avs_waitrequest;
   logic flash_cs_n;
   logic flash_sclk;
   logic [3:0] flash_io_o;
   logic [3:0] flash_io_oe;
   logic [3:0] io_d;
   wire logic [3:0] flash_io_i;
   int num_errors = 0;
   int tests_run = 0;
   snc_row_s rows [8] = '{
      '{`SNC_OP_WEN, 24'h0, `SNC_E_NONE, 1'b1},
      '{`SNC_OP_WDIS, 24'h0, `SNC_E_NONE, 1'b0},
      '{`SNC_OP_ERASE, 24'h0, `SNC_E_WEL, 1'b0},
      '{`SNC_OP_PEXEC, 24'h0, `SNC_E_WEL, 1'b0},
      '{`SNC_OP_LOAD, 24'h0, `SNC_E_WEL, 1'b0},
      '{8'hAB, 24'h0, `SNC_E_OPC, 1'b0},
      '{`SNC_OP_WEN, 24'h0, `SNC_E_NONE, 1'b1},
      '{`SNC_OP_PREAD, 24'h40, `SNC_E_NONE, 1'b0}};

   // Wire level: host where enabled, device elsewhere
   assign flash_io_i = (flash_io_oe & flash_io_o) | (~flash_io_oe & io_d);

   initial begin
      forever #2.5 mclk = ~mclk;
   end

   snc_host dut_u (
      .mclk(mclk), .rst(rst), .ce(ce), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .flash_cs_n(flash_cs_n), .flash_sclk(flash_sclk),
      .flash_io_o(flash_io_o), .flash_io_oe(flash_io_oe),
      .flash_io_i(flash_io_i)
   );

   snc_flash_model flash_u (
      .cs_n(flash_cs_n), .sclk(flash_sclk), .io_w(flash_io_i), .io_d(io_d)
   );

   task automatic test_done();
      if (num_errors == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp,
         input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One Avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [4:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 5000);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 5000) begin
         chk("bus_wait", 32'h0, 32'h1);
         test_done();
      end
   endtask

   // Frame end and device busy both gone; leaves status in rd
   task automatic idle();
      int n;
      n = 0;
      do begin
         bus(1'b0, `SNC_A_STAT, 32'h0);
         n++;
      end while ((rd[0] !== 1'b0 || flash_u.busy_q !== 1'b0) && n < 2000);
      if (n >= 2000) begin
         chk("idle_wait", 32'h0, 32'h1);
         test_done();
      end
   endtask

   task automatic op1(input logic [7:0] op, input logic [23:0] a);
      bus(1'b1, `SNC_A_ADDR, {8'h00, a});
      bus(1'b1, `SNC_A_CMD, {24'h0, op});
      idle();
   endtask

   // Latched two-byte load; second byte closes the frame
   task automatic load(input logic [7:0] op, input logic [23:0] col,
         input logic [7:0] b0, input logic [7:0] b1);
      op1(`SNC_OP_WEN, 24'h0);
      bus(1'b1, `SNC_A_ADDR, {8'h00, col});
      bus(1'b1, `SNC_A_CMD, {24'h0, op});
      bus(1'b1, `SNC_A_WDATA, {24'h0, b0});
      bus(1'b1, `SNC_A_WDATA, {23'h0, 1'b1, b1});
      idle();
   endtask

   initial begin
      repeat (8) @(posedge mclk);
      chk("rst_pins", 32'h60, 32'({avs_waitrequest, flash_cs_n, flash_sclk,
         flash_io_oe}));
      rst <= 1'b0;
      foreach (rows[i]) begin
         op1(rows[i].op, rows[i].addr);
         chk("refusal", 32'(rows[i].code), 32'(rd[7:5]));
         chk("wel_mirror", 32'(rows[i].write_enable_latch), 32'(rd[3]));
         chk("dev_wel", 32'(rows[i].write_enable_latch), 32'(flash_u.wel_q));
      end
      op1(`SNC_OP_RSR_A, 24'hA0);
      chk("sr1_pwrup", 32'h3E, 32'(rd[15:8]));
      op1(`SNC_OP_RSR_B, 24'hB0);
      chk("sr2_pwrup", 32'h10, 32'(rd[15:8]));
      bus(1'b1, `SNC_A_WDATA, 32'h0);
      op1(`SNC_OP_WSR_A, 24'hA0);
      bus(1'b1, `SNC_A_WDATA, 32'hFF);
      op1(`SNC_OP_WSR_B, 24'hB0);
      op1(`SNC_OP_RSR_A, 24'hA0);
      chk("sr1_wr", 32'h00, 32'(rd[15:8]));
      op1(`SNC_OP_RSR_B, 24'hB0);
      chk("sr2_wr", 32'hF0, 32'(rd[15:8]));
      load(`SNC_OP_LOAD, 24'h5, 8'hA5, 8'h3C);
      chk("buf5", 32'hA5, 32'(flash_u.buf_q[5]));
      chk("buf6", 32'h3C, 32'(flash_u.buf_q[6]));
      chk("buf0_fill", 32'hFF, 32'(flash_u.buf_q[0]));
      load(`SNC_OP_RLOAD, 24'h0, 8'h5A, 8'h5B);
      chk("buf0", 32'h5A, 32'(flash_u.buf_q[0]));
      chk("buf5_kept", 32'hA5, 32'(flash_u.buf_q[5]));
      load(`SNC_OP_LOAD, 24'h87F, 8'h77, 8'h88);
      chk("buf_last", 32'h77, 32'(flash_u.buf_q[2175]));
      chk("drop_flag", 32'h1, 32'(rd[4]));
      load(`SNC_OP_QLOAD, 24'h4, 8'hC3, 8'h96);
      chk("qbuf4", 32'hC3, 32'(flash_u.buf_q[4]));
      chk("qbuf5", 32'h96, 32'(flash_u.buf_q[5]));
      bus(1'b1, `SNC_A_CFG, 32'h1);
      op1(`SNC_OP_WEN, 24'h0);
      op1(`SNC_OP_QRLOAD, 24'h0);
      chk("wp_quad", 32'(`SNC_E_WP), 32'(rd[7:5]));
      bus(1'b1, `SNC_A_CFG, 32'h0);
      op1(`SNC_OP_PEXEC, 24'h1);
      chk("exec_wel", 32'h0, 32'(flash_u.wel_q));
      load(`SNC_OP_LOAD, 24'h0, 8'h11, 8'h22);
      op1(`SNC_OP_PREAD, 24'h1);
      chk("page_back", 32'hC3, 32'(flash_u.buf_q[4]));
      op1(`SNC_OP_WEN, 24'h0);
      op1(`SNC_OP_ERASE, 24'h1);
      op1(`SNC_OP_PREAD, 24'h1);
      chk("erased", 32'hFF, 32'(flash_u.buf_q[4]));
      bus(1'b1, `SNC_A_ADDR, 32'h0);
      bus(1'b1, `SNC_A_CMD, {24'h0, `SNC_OP_WEN});
      op1(`SNC_OP_WDIS, 24'h0);
      chk("busy_refuse", 32'(`SNC_E_BUSY), 32'(rd[7:5]));
      chk("wel_held", 32'h1, 32'(flash_u.wel_q));
      bus(1'b1, `SNC_A_CFG, 32'h1);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      bus(1'b0, `SNC_A_STAT, 32'h0);
      chk("stat_rst", 32'h0, rd);
      bus(1'b0, `SNC_A_CFG, 32'h0);
      chk("cfg_rst", 32'h0, rd);
      bus(1'b1, 5'h14, 32'hFF);
      bus(1'b0, 5'h14, 32'h0);
      chk("unmapped", 32'h0, rd);
      test_done();
   end
endmodule
